/* File: dtrr_regs.sv */
// Two-wire serial register file with temperature results and low-byte lock
`timescale 1ns/1ps
module dtrr_regs #(
  parameter logic [6:0] SLAVE_ADDR    = 7'h2c,
  parameter logic [7:0] MAKER_CODE    = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DIE_REV_CODE  = 8'h3c   // Arbitrary value
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               smb_clk,
  input  wire logic               smb_data_in,
  output logic                    smb_data_out,
  output logic                    smb_data_oe,
  input  wire logic signed  [9:0] local_temp,
  input  wire logic               local_update,
  input  wire logic signed [16:0] ch1_temp,
  input  wire logic               ch1_update,
  input  wire logic signed [16:0] ch2_temp,
  input  wire logic               ch2_update,
  input  wire logic               ch1_diode_absent,
  input  wire logic               ch2_diode_absent,
  output logic                    ch1_model_sel,
  output logic                    ch2_model_sel,
  output logic              [2:0] ch1_equation_mode_code,
  output logic              [2:0] ch2_equation_mode_code,
  output logic                    ch1_signed_format,
  output logic                    ch2_signed_format,
  output logic                    ch1_noise_filter_en,
  output logic                    ch2_noise_filter_en
);
  import dtrr_pkg::*;

  typedef struct packed {
    dtrr_bus_state_type bus;
    logic [7:0]         shift;
    logic [3:0]         bit_cnt;
    logic               got_addr;
    logic               got_cmd;
    logic               rd_mode;
    logic               more;
    logic [7:0]         pointer;
    logic               sda_oe;
    logic               sda_out;
    logic               scl_q;
    logic               sda_q;
    logic [2:0]         ch1_mode;
    logic [2:0]         ch2_mode;
    logic               ch1_model;
    logic               ch2_model;
    logic               ch1_fmt;
    logic               ch2_fmt;
    logic               ch1_filt;
    logic               ch2_filt;
    logic [2:0][7:0]    hi;
    logic [2:0][7:0]    lo;
    logic [2:0][7:0]    frz;
    logic [2:0]         lock;
  } dtrr_state_type;

  localparam dtrr_state_type STATE_RESET = '{
    bus:       BUS_IDLE,
    ch1_mode:  CH1_MODE_RESET,
    ch2_mode:  CH2_MODE_RESET,
    ch1_model: CH1_MODEL_RESET,
    ch2_model: CH2_MODEL_RESET,
    ch1_fmt:   FORMAT_RESET,
    ch2_fmt:   FORMAT_RESET,
    ch1_filt:  FILTER_RESET,
    ch2_filt:  FILTER_RESET,
    default:   '0
  };

  dtrr_state_type st;
  dtrr_state_type next_st;
  logic [1:0]     pins_sync;
  logic           scl_s;
  logic           sda_s;
  logic [15:0]    ch1_word;
  logic [15:0]    ch2_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and remote formatters

  dtrr_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({smb_clk, smb_data_in}),
    .sync_out (pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  dtrr_fmt u_fmt_ch1 (
    .raw_temp      (ch1_temp),
    .signed_format (st.ch1_fmt),
    .filter_en     (st.ch1_filt),
    .diode_absent  (ch1_diode_absent),
    .result_word   (ch1_word)
  );

  dtrr_fmt u_fmt_ch2 (
    .raw_temp      (ch2_temp),
    .signed_format (st.ch2_fmt),
    .filter_en     (st.ch2_filt),
    .diode_absent  (ch2_diode_absent),
    .result_word   (ch2_word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode; unmapped offsets read zero

  function automatic logic [7:0] read_value(input dtrr_state_type s, input logic [7:0] ptr);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      CONFIG_OFFSET: begin
        v[CH1_FORMAT_BIT] = s.ch1_fmt;
        v[CH2_FORMAT_BIT] = s.ch2_fmt;
      end
      FILTER_CTRL_OFFSET: begin
        v[CH1_FILTER_BIT] = s.ch1_filt;
        v[CH2_FILTER_BIT] = s.ch2_filt;
      end
      MODE_CTRL_OFFSET: begin
        v[CH1_MODE_LSB +: 3] = s.ch1_mode;
        v[CH2_MODE_LSB +: 3] = s.ch2_mode;
      end
      MODEL_SEL_OFFSET: begin
        v[CH1_MODEL_BIT] = s.ch1_model;
        v[CH2_MODEL_BIT] = s.ch2_model;
      end
      MAKER_ID_OFFSET: v = MAKER_CODE;
      DIE_REV_OFFSET:  v = DIE_REV_CODE;
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (ptr == TEMP_HIGH_OFFSET[i]) begin
            v = s.hi[i];
          end
          if (ptr == TEMP_LOW_OFFSET[i]) begin
            v = s.lock[i] ? s.frz[i] : s.lo[i];
          end
        end
      end
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic sclr;
    logic sclf;
    logic bus_start;
    logic bus_stop;
    logic do_load;
    logic do_write;
    sclr      = scl_s & ~st.scl_q;
    sclf      = ~scl_s & st.scl_q;
    bus_start = scl_s & st.scl_q & st.sda_q & ~sda_s;
    bus_stop  = scl_s & st.scl_q & ~st.sda_q & sda_s;
    do_load   = 1'b0;
    do_write  = 1'b0;
    next_st       = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;

    // Conversion results land in the live copies; a frozen low byte is separate
    if (local_update) begin
      next_st.hi[0] = local_temp[9:2];
      next_st.lo[0] = {local_temp[1:0], LOCAL_LOW_PAD};
    end
    if (ch1_update) begin
      next_st.hi[1] = ch1_word[15:8];
      next_st.lo[1] = ch1_word[7:0];
    end
    if (ch2_update) begin
      next_st.hi[2] = ch2_word[15:8];
      next_st.lo[2] = ch2_word[7:0];
    end

    if (bus_start) begin
      // Repeated start keeps the command byte for a read-byte transfer
      next_st.bus      = BUS_RX;
      next_st.bit_cnt  = 4'h0;
      next_st.got_addr = 1'b0;
      next_st.sda_oe   = 1'b0;
    end else if (bus_stop) begin
      next_st.bus      = BUS_IDLE;
      next_st.sda_oe   = 1'b0;
      next_st.got_addr = 1'b0;
      next_st.got_cmd  = 1'b0;
    end else begin
      unique case (st.bus)
        BUS_IDLE: begin
        end
        BUS_RX: begin
          if (sclr && st.bit_cnt != BITS_PER_BYTE) begin
            next_st.shift   = {st.shift[6:0], sda_s};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (sclf && st.bit_cnt == BITS_PER_BYTE) begin
            if (!st.got_addr) begin
              if (st.shift[7:1] == SLAVE_ADDR) begin
                next_st.got_addr = 1'b1;
                next_st.rd_mode  = st.shift[0];
                next_st.sda_oe   = 1'b1;
                next_st.bus      = BUS_ACK;
              end else begin
                next_st.bus = BUS_IDLE;
              end
            end else begin
              if (!st.got_cmd) begin
                next_st.pointer = st.shift;
                next_st.got_cmd = 1'b1;
              end else begin
                do_write = 1'b1;
              end
              next_st.sda_oe = 1'b1;
              next_st.bus    = BUS_ACK;
            end
          end
        end
        BUS_ACK: begin
          if (sclf) begin
            next_st.sda_oe  = 1'b0;
            next_st.bit_cnt = 4'h0;
            if (st.rd_mode) begin
              do_load     = 1'b1;
              next_st.bus = BUS_TX;
            end else begin
              next_st.bus = BUS_RX;
            end
          end
        end
        BUS_TX: begin
          if (sclf) begin
            if (st.bit_cnt == LAST_BIT) begin
              next_st.sda_oe = 1'b0;
              next_st.bus    = BUS_RACK;
            end else begin
              next_st.shift   = {st.shift[6:0], 1'b0};
              next_st.sda_oe  = ~st.shift[6];
              next_st.bit_cnt = st.bit_cnt + 4'h1;
            end
          end
        end
        BUS_RACK: begin
          if (sclr) begin
            next_st.more = ~sda_s;
          end else if (sclf) begin
            next_st.bit_cnt = 4'h0;
            if (st.more) begin
              do_load     = 1'b1;
              next_st.bus = BUS_TX;
            end else begin
              next_st.bus = BUS_IDLE;
            end
          end
        end
      endcase
    end

    // A byte is read when it is loaded for sending; that moment drives the lock
    if (do_load) begin
      next_st.shift  = read_value(st, st.pointer);
      next_st.sda_oe = ~next_st.shift[7];
      for (int i = 0; i < 3; i++) begin
        if (st.pointer == TEMP_HIGH_OFFSET[i]) begin
          // Pre-update value, matching the high byte just sent
          next_st.frz[i]  = st.lo[i];
          next_st.lock[i] = 1'b1;
        end
        if (st.pointer == TEMP_LOW_OFFSET[i]) begin
          next_st.lock[i] = 1'b0;
        end
      end
    end

    // Only writable registers decode; the rest drop the write
    if (do_write) begin
      case (st.pointer)
        CONFIG_OFFSET: begin
          next_st.ch1_fmt = st.shift[CH1_FORMAT_BIT];
          next_st.ch2_fmt = st.shift[CH2_FORMAT_BIT];
        end
        FILTER_CTRL_OFFSET: begin
          next_st.ch1_filt = st.shift[CH1_FILTER_BIT];
          next_st.ch2_filt = st.shift[CH2_FILTER_BIT];
        end
        MODE_CTRL_OFFSET: begin
          // Codes are stored as written; illegal ones are the host's concern
          next_st.ch1_mode = st.shift[CH1_MODE_LSB +: 3];
          next_st.ch2_mode = st.shift[CH2_MODE_LSB +: 3];
        end
        MODEL_SEL_OFFSET: begin
          next_st.ch1_model = st.shift[CH1_MODEL_BIT];
          next_st.ch2_model = st.shift[CH2_MODEL_BIT];
        end
        default: begin
        end
      endcase
    end
    next_st.sda_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register and outputs

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign smb_data_out           = st.sda_out;
  assign smb_data_oe            = st.sda_oe;
  assign ch1_model_sel          = st.ch1_model;
  assign ch2_model_sel          = st.ch2_model;
  assign ch1_equation_mode_code = st.ch1_mode;
  assign ch2_equation_mode_code = st.ch2_mode;
  assign ch1_signed_format      = st.ch1_fmt;
  assign ch2_signed_format      = st.ch2_fmt;
  assign ch1_noise_filter_en    = st.ch1_filt;
  assign ch2_noise_filter_en    = st.ch2_filt;
endmodule

/* File: dtrr_pkg.sv */
// Constants, register map and types shared by the temperature result register block
package dtrr_pkg;

  // Register offsets
  localparam logic [7:0] CONFIG_OFFSET      = 8'h03;
  localparam logic [7:0] FILTER_CTRL_OFFSET = 8'h06;
  localparam logic [7:0] MODE_CTRL_OFFSET   = 8'h07;
  localparam logic [7:0] MODEL_SEL_OFFSET   = 8'h30;
  localparam logic [7:0] MAKER_ID_OFFSET    = 8'hfe;
  localparam logic [7:0] DIE_REV_OFFSET     = 8'hff;
  // Index 0 local, 1 remote one, 2 remote two
  localparam logic [2:0][7:0] TEMP_HIGH_OFFSET = {8'h12, 8'h11, 8'h10};
  localparam logic [2:0][7:0] TEMP_LOW_OFFSET  = {8'h22, 8'h21, 8'h20};

  // Field positions
  localparam int CH1_MODE_LSB   = 0;
  localparam int CH2_MODE_LSB   = 4;
  localparam int CH1_MODEL_BIT  = 0;
  localparam int CH2_MODEL_BIT  = 2;
  localparam int CH1_FORMAT_BIT = 1;
  localparam int CH2_FORMAT_BIT = 2;
  localparam int CH1_FILTER_BIT = 0;
  localparam int CH2_FILTER_BIT = 2;

  // Values after reset
  localparam logic [2:0] CH1_MODE_RESET   = 3'h1;
  localparam logic [2:0] CH2_MODE_RESET   = 3'h0;
  localparam logic       CH1_MODEL_RESET  = 1'b1;
  localparam logic       CH2_MODEL_RESET  = 1'b0;
  localparam logic       FORMAT_RESET     = 1'b0;
  localparam logic       FILTER_RESET     = 1'b1;

  // Equation mode codes
  localparam logic [2:0] EQ_MODE_OFF     = 3'h0;
  localparam logic [2:0] EQ_MODE_ON      = 3'h1;
  localparam logic [2:0] EQ_MODE_ON_ALT  = 3'h7;

  // Remote result formatting
  localparam logic [15:0] LOW_MASK_FILTER_OFF = 16'hffe0;
  localparam logic [15:0] LOW_MASK_FILTER_ON  = 16'hfff8;
  localparam logic [15:0] ABSENT_UNSIGNED     = 16'hffe0;
  localparam logic [15:0] ABSENT_SIGNED       = 16'h8000;
  localparam logic [15:0] SIGNED_MAX_WORD     = 16'h7fff;
  localparam logic [15:0] SIGNED_MIN_WORD     = 16'h8000;
  localparam logic [15:0] UNSIGNED_MIN_WORD   = 16'h0000;
  localparam logic signed [16:0] RAW_SIGNED_MAX = 17'sh0_7fff;
  localparam logic signed [16:0] RAW_SIGNED_MIN = 17'sh1_8000;
  localparam logic [5:0] LOCAL_LOW_PAD        = 6'h00;

  // Serial byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_ACK,
    BUS_TX,
    BUS_RACK
  } dtrr_bus_state_type;

endpackage

/* File: dtrr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dtrr_sync (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  import dtrr_pkg::*;

  logic [1:0] stage1;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1   <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* File: dtrr_fmt.sv */
// Remote result formatter: range clamp, resolution mask and missing-diode code
`timescale 1ns/1ps
module dtrr_fmt (
  input  wire logic signed [16:0] raw_temp,
  input  wire logic               signed_format,
  input  wire logic               filter_en,
  input  wire logic               diode_absent,
  output logic             [15:0] result_word
);
  import dtrr_pkg::*;

  always_comb begin
    logic [15:0] clamped;
    clamped = raw_temp[15:0];
    if (signed_format) begin
      if (raw_temp < RAW_SIGNED_MIN) begin
        clamped = SIGNED_MIN_WORD;
      end else if (raw_temp > RAW_SIGNED_MAX) begin
        clamped = SIGNED_MAX_WORD;
      end
    end else if (raw_temp < 17'sh0_0000) begin
      clamped = UNSIGNED_MIN_WORD;
    end
    // Filter widens the fraction from three to five bits
    result_word = clamped & (filter_en ? LOW_MASK_FILTER_ON : LOW_MASK_FILTER_OFF);
    if (diode_absent) begin
      result_word = signed_format ? ABSENT_SIGNED : ABSENT_UNSIGNED;
    end
  end
endmodule

/* File: dtrr_regs_monitor.sv */
// Port checker for the temperature result register block
`timescale 1ns/1ps
module dtrr_regs_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       smb_clk,
  input wire logic       smb_data_oe,
  input wire logic       ch1_model_sel,
  input wire logic       ch2_model_sel,
  input wire logic [2:0] ch1_equation_mode_code,
  input wire logic [2:0] ch2_equation_mode_code,
  input wire logic       ch1_signed_format,
  input wire logic       ch2_signed_format,
  input wire logic       ch1_noise_filter_en,
  input wire logic       ch2_noise_filter_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_MODEL_RST: assert property ($fell(sys_rst) |-> ch1_model_sel && !ch2_model_sel)
    else $error("model select bits not at reset value");
  AST_MODE_RST: assert property ($fell(sys_rst) |->
    ch1_equation_mode_code == 3'h1 && ch2_equation_mode_code == 3'h0)
    else $error("mode codes not at reset value");
  AST_FMT_RST: assert property ($fell(sys_rst) |-> !ch1_signed_format && !ch2_signed_format)
    else $error("format bits not unsigned after reset");
  AST_FILT_RST: assert property ($fell(sys_rst) |-> ch1_noise_filter_en && ch2_noise_filter_en)
    else $error("filter enables not set after reset");
  // Mode codes and model selects may only move a few cycles after a serial clock fall
  AST_MODE1_CHG: assert property (!$stable(ch1_equation_mode_code) |->
    !smb_clk && $past(smb_clk, 5))
    else $error("channel one mode changed outside a write");
  AST_MODE2_CHG: assert property ($changed(ch2_equation_mode_code) |->
    $past(smb_clk, 5) && !smb_clk)
    else $error("channel two mode changed outside a write");
  AST_MODEL_CHG: assert property ($changed({ch2_model_sel, ch1_model_sel}) |->
    !smb_clk ##0 $past(smb_clk, 5))
    else $error("model select changed outside a write");
  AST_OE_HOLD: assert property ($rose(smb_data_oe) |-> smb_data_oe [*4])
    else $error("data pull-down released too early");
endmodule
bind dtrr_regs dtrr_regs_monitor i_dtrr_regs_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
  .smb_clk(smb_clk), .smb_data_oe(smb_data_oe), .ch1_model_sel(ch1_model_sel),
  .ch2_model_sel(ch2_model_sel), .ch1_equation_mode_code(ch1_equation_mode_code),
  .ch2_equation_mode_code(ch2_equation_mode_code), .ch1_signed_format(ch1_signed_format),
  .ch2_signed_format(ch2_signed_format), .ch1_noise_filter_en(ch1_noise_filter_en),
  .ch2_noise_filter_en(ch2_noise_filter_en));

/* File: dtrr_host.sv */
// Serial bus host model that reads and writes the register block
`timescale 1ns/1ps
module dtrr_host (
  output logic     smb_clk,
  output logic     host_sda,
  input wire logic sda_wire
);
  // Clock rests high between frames; data is released to the pull-up
  initial begin
    smb_clk = 1'b1;
    host_sda = 1'b1;
  end
  task automatic bit_out(input logic b);
    host_sda = b;
    #100 smb_clk = 1'b1;
    #200 smb_clk = 1'b0;
    #100;
  endtask
  task automatic bit_in(output logic b);
    host_sda = 1'b1;
    #100 smb_clk = 1'b1;
    #100 b = sda_wire;
    #100 smb_clk = 1'b0;
    #100;
  endtask
  task automatic start_cond;
    host_sda = 1'b1;
    #100 smb_clk = 1'b1;
    #200 host_sda = 1'b0;
    #200 smb_clk = 1'b0;
    #100;
  endtask
  task automatic stop_cond;
    host_sda = 1'b0;
    #100 smb_clk = 1'b1;
    #200 host_sda = 1'b1;
    #200;
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = !a;
  endtask
  task automatic write_reg(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] d,
                           output logic ok);
    logic a1, a2, a3;
    start_cond;
    byte_out({adr, 1'b0}, a1);
    byte_out(ptr, a2);
    byte_out(d, a3);
    stop_cond;
    ok = a1 & a2 & a3;
  endtask
  // Ends every read with a refusal so the device lets go of the line
  task automatic read_reg(input logic [6:0] adr, input logic [7:0] ptr, output logic [7:0] d,
                          output logic ok);
    logic a1, a2, a3, b;
    start_cond;
    byte_out({adr, 1'b0}, a1);
    byte_out(ptr, a2);
    start_cond;
    byte_out({adr, 1'b1}, a3);
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(1'b1);
    stop_cond;
    ok = a1 & a2 & a3;
  endtask
endmodule

/* File: tb_dtrr_regs.sv */
// Self-checking bench for the temperature result register block
`timescale 1ns/1ps
module tb_dtrr_regs;
  import dtrr_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h2c;
  localparam logic [7:0] MAKER    = 8'h3a;  // Arbitrary value
  localparam logic [7:0] DIE_REV  = 8'h6d;  // Arbitrary value
  logic               core_clk, sys_rst, smb_clk, host_sda, smb_data_out, smb_data_oe;
  logic               local_update, ch1_update, ch2_update, ch1_diode_absent, ch2_diode_absent;
  logic signed  [9:0] local_temp;
  logic signed [16:0] ch1_temp, ch2_temp;
  logic         [2:0] ch1_equation_mode_code, ch2_equation_mode_code;
  logic               ch1_model_sel, ch2_model_sel, ch1_signed_format, ch2_signed_format;
  logic               ch1_noise_filter_en, ch2_noise_filter_en;
  int                 err_total = 0;
  int                 tests_run = 0;
  wire                sda_wire = host_sda & ~smb_data_oe;
  dtrr_regs #(.SLAVE_ADDR(DEV_ADDR), .MAKER_CODE(MAKER), .DIE_REV_CODE(DIE_REV)) i_dtrr_regs (
    .core_clk(core_clk), .sys_rst(sys_rst), .smb_clk(smb_clk), .smb_data_in(sda_wire),
    .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .local_temp(local_temp),
    .local_update(local_update), .ch1_temp(ch1_temp), .ch1_update(ch1_update),
    .ch2_temp(ch2_temp), .ch2_update(ch2_update), .ch1_diode_absent(ch1_diode_absent),
    .ch2_diode_absent(ch2_diode_absent), .ch1_model_sel(ch1_model_sel),
    .ch2_model_sel(ch2_model_sel), .ch1_equation_mode_code(ch1_equation_mode_code),
    .ch2_equation_mode_code(ch2_equation_mode_code), .ch1_signed_format(ch1_signed_format),
    .ch2_signed_format(ch2_signed_format), .ch1_noise_filter_en(ch1_noise_filter_en),
    .ch2_noise_filter_en(ch2_noise_filter_en));
  dtrr_host i_dtrr_host (.smb_clk(smb_clk), .host_sda(host_sda), .sda_wire(sda_wire));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
    logic ok;
    i_dtrr_host.write_reg(DEV_ADDR, ptr, val, ok);
    chk("write ack", 16'(ok), 16'h0001);
  endtask
  // A refused read yields unknown data so any compare of that data fails
  task automatic rd(input logic [7:0] ptr, output logic [7:0] val);
    logic ok;
    i_dtrr_host.read_reg(DEV_ADDR, ptr, val, ok);
    if (ok !== 1'b1) val = 8'hxx;
  endtask
  task automatic rd_pair(input int idx, output logic [15:0] w);
    rd(TEMP_HIGH_OFFSET[idx], w[15:8]);
    rd(TEMP_LOW_OFFSET[idx], w[7:0]);
  endtask
  function automatic logic [15:0] rexp(input logic [16:0] raw, input logic sgn, filt, absent);
    if (absent) return sgn ? 16'h8000 : 16'hffe0;
    return raw[15:0] & {8'hff, filt ? 8'hf8 : 8'he0};
  endfunction
  task automatic conv(input int ch, input logic [16:0] raw, input logic absent);
    @(posedge core_clk);
    #2;
    local_temp = raw[9:0];
    if (ch == 1) {ch1_temp, ch1_diode_absent, ch1_update} = {raw, absent, 1'b1};
    else if (ch == 2) {ch2_temp, ch2_diode_absent, ch2_update} = {raw, absent, 1'b1};
    else local_update = 1'b1;
    @(posedge core_clk);
    #2;
    {local_update, ch1_update, ch2_update} = 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    logic [7:0] d;
    rd(MODE_CTRL_OFFSET, d);
    chk("mode reg", 16'(d), 16'h0001);
    rd(MODEL_SEL_OFFSET, d);
    chk("model reg", 16'(d), 16'h0001);
    rd(FILTER_CTRL_OFFSET, d);
    chk("filter reg", 16'(d), 16'h0005);
    rd(CONFIG_OFFSET, d);
    chk("config reg", 16'(d), 16'h0000);
    rd(MAKER_ID_OFFSET, d);
    chk("maker", 16'(d), 16'(MAKER));
    rd(DIE_REV_OFFSET, d);
    chk("die rev", 16'(d), 16'(DIE_REV));
    chk("data out", 16'(smb_data_out), 16'h0000);
    $display("test_reset done");
  endtask
  task automatic test_ctrl;
    logic [2:0] codes [3];
    logic [7:0] m, d;
    codes = '{3'h0, 3'h1, 3'h7};
    for (int i = 0; i < 3; i++) begin
      m = {1'b0, codes[(i + 1) % 3], 1'b0, codes[i]};
      wr(MODE_CTRL_OFFSET, m);
      rd(MODE_CTRL_OFFSET, d);
      chk("mode reg", 16'(d), 16'(m));
      chk("mode out", 16'({ch2_equation_mode_code, ch1_equation_mode_code}),
          16'({m[6:4], m[2:0]}));
    end
    wr(MODEL_SEL_OFFSET, 8'hff);
    rd(MODEL_SEL_OFFSET, d);
    chk("model reg", 16'(d), 16'h0005);
    wr(MODEL_SEL_OFFSET, 8'h04);
    rd(MODEL_SEL_OFFSET, d);
    chk("model reg", 16'(d), 16'h0004);
    chk("model out", 16'({ch2_model_sel, ch1_model_sel}), 16'h0002);
    $display("test_ctrl done");
  endtask
  task automatic test_results;
    logic [15:0] w;
    conv(0, 17'h0_02d3, 1'b0);
    rd_pair(0, w);
    chk("local", w, 16'hb4c0);
    wr(CONFIG_OFFSET, 8'h04);
    wr(FILTER_CTRL_OFFSET, 8'h01);
    chk("fmt out", 16'({ch2_signed_format, ch1_signed_format}), 16'h0002);
    chk("filt out", 16'({ch2_noise_filter_en, ch1_noise_filter_en}), 16'h0001);
    conv(1, 17'h0_c8f4, 1'b0);
    rd_pair(1, w);
    chk("remote1", w, rexp(17'h0_c8f4, 1'b0, 1'b1, 1'b0));
    conv(2, 17'h1_fa84, 1'b0);
    rd_pair(2, w);
    chk("remote2", w, rexp(17'h1_fa84, 1'b1, 1'b0, 1'b0));
    conv(1, 17'h0_1000, 1'b1);
    conv(2, 17'h0_1000, 1'b1);
    rd_pair(1, w);
    chk("absent1", w, 16'hffe0);
    rd_pair(2, w);
    chk("absent2", w, 16'h8000);
    $display("test_results done");
  endtask
  task automatic test_lock;
    logic [15:0] a, b, c, e;
    logic [7:0]  d;
    logic        ok;
    a = rexp(17'h0_1234, 1'b0, 1'b1, 1'b0);
    b = rexp(17'h0_2358, 1'b0, 1'b1, 1'b0);
    c = rexp(17'h0_3478, 1'b0, 1'b1, 1'b0);
    e = rexp(17'h0_45e8, 1'b0, 1'b1, 1'b0);
    conv(1, 17'h0_1234, 1'b0);
    rd(8'h11, d);
    conv(1, 17'h0_2358, 1'b0);
    rd(8'h21, d);
    chk("frozen low", 16'(d), 16'(a[7:0]));
    rd(8'h21, d);
    chk("live low", 16'(d), 16'(b[7:0]));
    rd(8'h11, d);
    conv(1, 17'h0_3478, 1'b0);
    rd(8'h11, d);
    chk("high c", 16'(d), 16'(c[15:8]));
    conv(1, 17'h0_45e8, 1'b0);
    wr(8'h21, 8'h55);
    wr(8'h11, 8'haa);
    wr(MAKER_ID_OFFSET, 8'h00);
    rd(8'h21, d);
    chk("refrozen low", 16'(d), 16'(c[7:0]));
    rd(8'h11, d);
    chk("high e", 16'(d), 16'(e[15:8]));
    rd(MAKER_ID_OFFSET, d);
    chk("maker", 16'(d), 16'(MAKER));
    rd(8'h40, d);
    chk("unmapped", 16'(d), 16'h0000);
    i_dtrr_host.read_reg(7'h2d, MAKER_ID_OFFSET, d, ok);
    chk("foreign addr", 16'(ok), 16'h0000);
    $display("test_lock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {sys_rst, local_update, ch1_update, ch2_update, ch1_diode_absent, ch2_diode_absent} = 6'h20;
    {local_temp, ch1_temp, ch2_temp} = '0;
    repeat (8) @(posedge core_clk);
    #2 sys_rst = 1'b0;
    repeat (3) @(posedge core_clk);
    // Host edges then land just after core clock edges, never on them
    #2;
    test_reset;
    test_ctrl;
    test_results;
    test_lock;
    final_report;
  end
  // About three times the expected run length
  initial begin
    #2_000_000;
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    final_report;
  end
endmodule
